// file: srmc_pkg.sv
// Purpose: Shared constants and types of the serial flash read mode control block.
// Assumes: Opcodes not fixed elsewhere are plain defaults and may be retuned.
// Notes:   All timing is counted in serial clock edges seen by the core clock.
package srmc_pkg;

  // ----------------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------------
  localparam logic [7:0] OP_QUAD_IO_READ            = 8'heb;
  localparam logic [7:0] OP_WIDE_ADDR_QUAD_IO_READ  = 8'hec;
  localparam logic [7:0] OP_DDR_QUAD_READ           = 8'hed;
  localparam logic [7:0] OP_WIDE_ADDR_DDR_QUAD_READ = 8'hee;
  localparam logic [7:0] OP_DUAL_IO_READ            = 8'hbb;
  localparam logic [7:0] OP_WIDE_ADDR_DUAL_IO_READ  = 8'hbc;
  localparam logic [7:0] OP_SET_BURST_LENGTH        = 8'hc0;

  // ----------------------------------------------------------------------
  // Phase lengths in bits or clocks
  // ----------------------------------------------------------------------
  localparam logic [5:0] CMD_BITS        = 6'd8;
  localparam logic [5:0] ADDR_BITS_SHORT = 6'd24;
  localparam logic [5:0] ADDR_BITS_WIDE  = 6'd32;
  localparam logic [5:0] IND_BITS        = 6'd8;
  localparam logic [5:0] WRAP_CODE_BITS  = 6'd8;
  localparam logic [3:0] RST_CLKS_SHORT  = 4'd8;
  localparam logic [3:0] RST_CLKS_WIDE   = 4'd10;
  localparam logic [5:0] DUMMY_DC00      = 6'd4;
  localparam logic [5:0] DUMMY_DC01      = 6'd6;
  localparam logic [5:0] DUMMY_DC10      = 6'd8;
  localparam logic [5:0] DUMMY_DC11      = 6'd10;

  // ----------------------------------------------------------------------
  // Wrap codes and reset values
  // ----------------------------------------------------------------------
  localparam logic [3:0] WRAP_OFF_NIBBLE = 4'h1;
  localparam logic [5:0] WRAP_BASE_BYTES = 6'd8;
  localparam logic [1:0] WRAP_DEPTH_RST  = 2'h0;
  localparam logic       WRAP_EN_RST     = 1'b0;
  localparam logic       ENHANCE_RST     = 1'b0;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_IND, ST_DUMMY, ST_DATA, ST_WRAP, ST_IGNORE
  } srmc_state_t;

  typedef struct packed {
    logic quad_command_mode;
    logic wide_addr_mode;
    logic quad_enable_bit;
    logic dummy_count_high;
    logic dummy_count_low;
  } srmc_cfg_t;

  typedef struct packed {
    logic       enhance_mode;
    logic       wrap_enable;
    logic [1:0] wrap_depth;
  } srmc_status_t;

  typedef struct packed {
    logic quad;
    logic dual;
    logic ddr;
    logic wide;
    logic wrap_ok;
    logic burst;
  } srmc_op_t;

endpackage

// file: srmc_core.sv
// Purpose: Command front end of a multi-lane serial flash for wide address
//          reads, continuous read (enhance) mode and wrapped burst reads.
// Assumes: The serial clock is several core clocks long in each half period.
// Notes:   Array data arrives through a two-entry buffer ahead of the shifter.

// Function
// R01 - Wide commands take exactly four address bytes.
// R02 - Wide commands work without wide mode.
// R03 - Enhance mode for quad reads, both modes.
// R04 - Dual reads never enter enhance mode.
// R05 - Toggling indicator enters or keeps enhance.
// R06 - Equal indicator pair leaves enhance mode.
// R07 - Enhance frame skips instruction, starts address.
// R08 - Ones on lane zero reset enhance.
// R09 - Ones on four lanes reset enhance.
// R10 - Reset drops enhance and read state.
// R11 - Address, indicator, dummies, data until deselect.
// R12 - Dummy count from configuration bits.
// R13 - Host keeps indicator constant to avoid enhance.
// R14 - Wrap disabled after reset.
// R15 - Wrap inside aligned block of chosen size.
// R16 - Burst length: instruction, code, deselect.
// R17 - Codes 00h-03h set depth, 1xh disables.
// R18 - Wrap persists; new code replaces it.
// R19 - Only quad io reads apply wrap.
// R20 - Burst instruction in eight or two clocks.
// R21 - Host sets quad enable before quad reads.
// R22 - Indicator sampled like the address phase.
// R23 - Enhance cleared at power up.
module srmc_core (
  input  wire logic                   clock,
  input  wire logic                   rstn,
  input  wire logic                   sclk,
  input  wire logic                   chip_select_n,
  input  wire logic [3:0]             io_lines_in,
  output logic      [3:0]             io_lines_out,
  output logic      [3:0]             io_lines_oe,
  input  wire srmc_pkg::srmc_cfg_t    cfg,
  output srmc_pkg::srmc_status_t      status,
  output logic                        array_en,
  output logic      [31:0]            array_addr,
  input  wire logic                   array_valid,
  input  wire logic [7:0]             array_data,
  output logic                        array_ready
);

  // ----------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------------
  logic [1:0] sclk_q;
  logic [1:0] cs_q;
  logic [3:0] io_q1;
  logic [3:0] io_q2;
  logic       sclk_d;
  logic       cs_d;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      sclk_q <= 2'h0;
      cs_q   <= 2'h3;
      io_q1  <= 4'h0;
      io_q2  <= 4'h0;
      sclk_d <= 1'b0;
      cs_d   <= 1'b1;
    end else begin
      sclk_q <= {sclk_q[0], sclk};
      cs_q   <= {cs_q[0], chip_select_n};
      io_q1  <= io_lines_in;
      io_q2  <= io_q1;
      sclk_d <= sclk_q[1];
      cs_d   <= cs_q[1];
    end
  end

  logic rise;
  logic fall;
  logic cs_fall;
  logic cs_rise;

  assign rise    = sclk_q[1] & ~sclk_d & ~cs_q[1];
  assign fall    = ~sclk_q[1] & sclk_d & ~cs_q[1];
  assign cs_fall = ~cs_q[1] & cs_d;
  assign cs_rise = cs_q[1] & ~cs_d;

  // ----------------------------------------------------------------------
  // Opcode decode
  // ----------------------------------------------------------------------
  function automatic srmc_pkg::srmc_op_t decode(input logic [7:0] c);
    srmc_pkg::srmc_op_t d;
    d = '0;
    case (c)
      srmc_pkg::OP_QUAD_IO_READ: begin
        d.quad    = 1'b1;
        d.wrap_ok = 1'b1;
      end
      srmc_pkg::OP_WIDE_ADDR_QUAD_IO_READ: begin
        d.quad    = 1'b1;
        d.wide    = 1'b1;
        d.wrap_ok = 1'b1;
      end
      srmc_pkg::OP_DDR_QUAD_READ: begin
        d.quad = 1'b1;
        d.ddr  = 1'b1;
      end
      srmc_pkg::OP_WIDE_ADDR_DDR_QUAD_READ: begin
        d.quad = 1'b1;
        d.ddr  = 1'b1;
        d.wide = 1'b1;
      end
      srmc_pkg::OP_DUAL_IO_READ: begin
        d.dual = 1'b1;
      end
      srmc_pkg::OP_WIDE_ADDR_DUAL_IO_READ: begin
        d.dual = 1'b1;
        d.wide = 1'b1;
      end
      srmc_pkg::OP_SET_BURST_LENGTH: begin
        d.burst = 1'b1;
      end
      default: begin
        d = '0;
      end
    endcase
    return d;
  endfunction

  // ----------------------------------------------------------------------
  // Phase control
  // ----------------------------------------------------------------------
  srmc_pkg::srmc_state_t state;
  srmc_pkg::srmc_state_t next_state;
  srmc_pkg::srmc_op_t    op;
  srmc_pkg::srmc_op_t    cmd_op;
  logic [5:0]            cnt;
  logic [31:0]           sh;
  logic [31:0]           next_sh;
  logic [2:0]            lanes;
  logic [5:0]            target;
  logic [5:0]            abits;
  logic [5:0]            dummy_n;
  logic                  cap;
  logic                  done;
  logic                  force_exit;
  logic                  enhance;

  // Wide opcodes carry 32 address bits even when wide mode is off.
  assign abits = (op.wide || cfg.wide_addr_mode) ? srmc_pkg::ADDR_BITS_WIDE
                                                 : srmc_pkg::ADDR_BITS_SHORT; // R01 R02

  always_comb begin
    unique case ({cfg.dummy_count_high, cfg.dummy_count_low}) // R12
      2'b00: dummy_n = srmc_pkg::DUMMY_DC00;
      2'b01: dummy_n = srmc_pkg::DUMMY_DC01;
      2'b10: dummy_n = srmc_pkg::DUMMY_DC10;
      2'b11: dummy_n = srmc_pkg::DUMMY_DC11;
    endcase
  end

  always_comb begin
    lanes  = 3'd1;
    target = srmc_pkg::CMD_BITS;
    if (state == srmc_pkg::ST_CMD || state == srmc_pkg::ST_WRAP) begin
      lanes  = cfg.quad_command_mode ? 3'd4 : 3'd1; // R20
      target = srmc_pkg::CMD_BITS;
    end else if (state == srmc_pkg::ST_ADDR) begin
      lanes  = op.quad ? 3'd4 : 3'd2;
      target = abits; // R01
    end else if (state == srmc_pkg::ST_IND) begin
      lanes  = 3'd4; // R22
      target = srmc_pkg::IND_BITS;
    end
  end

  // Double rate reads also sample address and indicator on falling edges.
  assign cap = rise | (fall & op.ddr &
                       (state == srmc_pkg::ST_ADDR || state == srmc_pkg::ST_IND)); // R22

  always_comb begin
    unique case (lanes)
      3'd4:    next_sh = {sh[27:0], io_q2};
      3'd2:    next_sh = {sh[29:0], io_q2[1:0]};
      default: next_sh = {sh[30:0], io_q2[0]}; // R20
    endcase
  end

  assign done   = cap && ((cnt + 6'(lanes)) == target);
  assign cmd_op = decode(next_sh[7:0]);

  always_comb begin
    next_state = state;
    unique case (state)
      srmc_pkg::ST_IDLE:
        if (cs_fall) begin
          next_state = enhance ? srmc_pkg::ST_ADDR : srmc_pkg::ST_CMD; // R07
        end
      srmc_pkg::ST_CMD:
        if (done) begin
          if (cmd_op.burst) begin
            next_state = srmc_pkg::ST_WRAP; // R16
          end else if (cmd_op.dual ||
                       (cmd_op.quad && (cfg.quad_command_mode || cfg.quad_enable_bit))) begin
            next_state = srmc_pkg::ST_ADDR; // R03 R21
          end else begin
            next_state = srmc_pkg::ST_IGNORE;
          end
        end
      srmc_pkg::ST_ADDR:
        if (done) begin
          next_state = op.quad ? srmc_pkg::ST_IND : srmc_pkg::ST_DUMMY; // R04 R11
        end
      srmc_pkg::ST_IND:
        if (done) begin
          next_state = srmc_pkg::ST_DUMMY; // R11
        end
      srmc_pkg::ST_DUMMY:
        if (rise && (cnt + 6'd1) >= dummy_n) begin
          next_state = srmc_pkg::ST_DATA; // R12
        end
      srmc_pkg::ST_WRAP:
        if (done) begin
          next_state = srmc_pkg::ST_IGNORE;
        end
      srmc_pkg::ST_DATA,
      srmc_pkg::ST_IGNORE: next_state = state;
    endcase
    if (force_exit) begin
      next_state = srmc_pkg::ST_IGNORE;
    end
    if (cs_rise) begin
      next_state = srmc_pkg::ST_IDLE; // R11
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state <= srmc_pkg::ST_IDLE; // R10
      cnt   <= 6'h00;
      sh    <= 32'h0;
      op    <= '0;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        cnt <= 6'h00;
      end else if (state == srmc_pkg::ST_DUMMY && rise) begin
        cnt <= cnt + 6'd1;
      end else if (cap && state != srmc_pkg::ST_IDLE) begin
        cnt <= cnt + 6'(lanes);
      end
      if (cap) begin
        sh <= next_sh;
      end
      // The opcode is kept across frames so an enhance frame reuses it.
      if (state == srmc_pkg::ST_CMD && done) begin
        op <= cmd_op; // R07
      end
    end
  end

  // ----------------------------------------------------------------------
  // Enhance mode
  // ----------------------------------------------------------------------
  logic       frame_enh;
  logic       ones_ok;
  logic [3:0] ones_cnt;
  logic [3:0] rst_len;
  logic       ones_now;

  assign rst_len  = (op.wide || cfg.wide_addr_mode) ? srmc_pkg::RST_CLKS_WIDE
                                                    : srmc_pkg::RST_CLKS_SHORT; // R08 R09
  assign ones_now = cfg.quad_command_mode ? (&io_q2) : io_q2[0]; // R08 R09
  assign force_exit = frame_enh && ones_ok && rise && ones_now &&
                      (ones_cnt + 4'd1) == rst_len &&
                      (state == srmc_pkg::ST_ADDR || state == srmc_pkg::ST_IND);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      frame_enh <= 1'b0;
      ones_ok   <= 1'b0;
      ones_cnt  <= 4'h0;
    end else if (cs_fall) begin
      frame_enh <= enhance;
      ones_ok   <= 1'b1;
      ones_cnt  <= 4'h0;
    end else if (rise && frame_enh && ones_ok) begin
      ones_ok  <= ones_now;
      ones_cnt <= ones_cnt + 4'd1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      enhance <= srmc_pkg::ENHANCE_RST; // R10 R23
    end else if (force_exit) begin
      enhance <= 1'b0; // R08 R09
    end else if (state == srmc_pkg::ST_IND && done) begin
      // Any equal bit pair ends the mode; the next frame decodes an opcode.
      enhance <= op.quad & (&(next_sh[7:4] ^ next_sh[3:0])); // R03 R04 R05 R06
    end
  end

  // ----------------------------------------------------------------------
  // Burst wrap configuration
  // ----------------------------------------------------------------------
  logic       wrap_en;
  logic [1:0] wrap_depth;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      wrap_en    <= srmc_pkg::WRAP_EN_RST; // R14
      wrap_depth <= srmc_pkg::WRAP_DEPTH_RST;
    end else if (state == srmc_pkg::ST_WRAP && done) begin
      if (next_sh[7:4] == srmc_pkg::WRAP_OFF_NIBBLE) begin
        wrap_en <= 1'b0; // R17 R18
      end else if (next_sh[7:2] == 6'h00) begin
        wrap_en    <= 1'b1; // R17 R18
        wrap_depth <= next_sh[1:0];
      end
    end
  end

  assign status = '{enhance_mode: enhance, wrap_enable: wrap_en, wrap_depth: wrap_depth};

  // ----------------------------------------------------------------------
  // Array fetch and two-entry buffer
  // ----------------------------------------------------------------------
  logic [7:0]  fifo_mem [0:1];
  logic        wp;
  logic        rp;
  logic [1:0]  fcnt;
  logic        push;
  logic        pop;
  logic [5:0]  wrap_mask;
  logic [31:0] inc_addr;

  assign array_en    = (state == srmc_pkg::ST_DUMMY) || (state == srmc_pkg::ST_DATA);
  // The buffer stalls the array once both entries hold unsent bytes.
  assign array_ready = array_en && (fcnt != 2'd2);
  assign push        = array_valid && array_ready;
  assign wrap_mask   = 6'((srmc_pkg::WRAP_BASE_BYTES << wrap_depth) - 6'd1);
  assign inc_addr    = array_addr + 32'h1;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      array_addr <= 32'h0;
    end else if (state == srmc_pkg::ST_ADDR && done) begin
      array_addr <= (abits == srmc_pkg::ADDR_BITS_WIDE) ? next_sh
                                                         : {8'h00, next_sh[23:0]}; // R01
    end else if (push) begin
      if (wrap_en && op.wrap_ok) begin
        array_addr <= {array_addr[31:6],
                       (array_addr[5:0] & ~wrap_mask) | (inc_addr[5:0] & wrap_mask)}; // R15 R19
      end else begin
        array_addr <= inc_addr; // R19
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn || !array_en) begin
      wp   <= 1'b0;
      rp   <= 1'b0;
      fcnt <= 2'd0;
    end else begin
      if (push) begin
        fifo_mem[wp] <= array_data;
        wp           <= ~wp;
      end
      if (pop) begin
        rp <= ~rp;
      end
      fcnt <= fcnt + 2'(push) - 2'(pop);
    end
  end

  // ----------------------------------------------------------------------
  // Data shifter
  // ----------------------------------------------------------------------
  logic [7:0] dsh;
  logic [3:0] dleft;
  logic [7:0] cur;
  logic       drive;

  assign drive = (state == srmc_pkg::ST_DATA) && (fall || (op.ddr && rise)); // R11
  assign pop   = drive && (dleft == 4'd0) && (fcnt != 2'd0);
  // An empty buffer at a byte start shifts zeros; the array must keep pace.
  assign cur   = (dleft != 4'd0) ? dsh : ((fcnt != 2'd0) ? fifo_mem[rp] : 8'h00);

  always_ff @(posedge clock) begin
    if (!rstn || state != srmc_pkg::ST_DATA) begin
      io_lines_out <= 4'h0;
      io_lines_oe  <= 4'h0;
      dsh          <= 8'h00;
      dleft        <= 4'd0;
    end else begin
      io_lines_oe <= op.quad ? 4'hf : 4'h3;
      if (drive) begin
        if (op.quad) begin
          io_lines_out <= cur[7:4];
          dsh          <= {cur[3:0], 4'h0};
          dleft        <= (dleft == 4'd0) ? 4'd4 : dleft - 4'd4;
        end else begin
          io_lines_out <= {2'b00, cur[7:6]};
          dsh          <= {cur[5:0], 2'b00};
          dleft        <= (dleft == 4'd0) ? 4'd6 : dleft - 4'd2;
        end
      end
    end
  end

endmodule

// file: srmc_core_chk.sv
// Purpose: Port checks for srmc_core.
// Assumes: One clock domain; rstn is synchronous and active low.
// Notes:   Bound to every srmc_core instance.
module srmc_core_chk (
  input wire logic                   clock,
  input wire logic                   rstn,
  input wire logic                   sclk,
  input wire logic                   chip_select_n,
  input wire logic [3:0]             io_lines_in,
  input wire logic [3:0]             io_lines_out,
  input wire logic [3:0]             io_lines_oe,
  input wire srmc_pkg::srmc_cfg_t    cfg,
  input wire srmc_pkg::srmc_status_t status,
  input wire logic                   array_en,
  input wire logic [31:0]            array_addr,
  input wire logic                   array_valid,
  input wire logic [7:0]             array_data,
  input wire logic                   array_ready
);
  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  property p_rst;
    disable iff (1'b0) !rstn |=> status == '0 && io_lines_oe == 4'h0 && !array_en;
  endproperty
  property p_oe_idle;
    chip_select_n [*6] |-> io_lines_oe == 4'h0;
  endproperty
  property p_idle;
    chip_select_n [*6] |-> !array_en && !array_ready;
  endproperty
  // Lanes are released one clock after the data phase ends.
  property p_oe_data;
    !array_en |=> io_lines_oe == 4'h0;
  endproperty
  // A two-lane data phase belongs to a dual read, which never enters enhance mode.
  property p_dual_enh;
    io_lines_oe == 4'h3 |-> !status.enhance_mode;
  endproperty
  property p_step;
    array_valid && array_ready && !status.wrap_enable |=>
      array_addr == $past(array_addr) + 32'h1;
  endproperty
  // The address may only move on an accepted byte once data flows.
  property p_hold;
    array_en && !(array_valid && array_ready) |=> $stable(array_addr) || !array_en;
  endproperty
  property p_wrap;
    chip_select_n [*8] |=> $stable(status[2:0]);
  endproperty
  property p_enh;
    chip_select_n [*8] |=> $stable(status.enhance_mode);
  endproperty
  property p_lanes;
    io_lines_oe == 4'h0 || io_lines_oe == 4'h3 || io_lines_oe == 4'hf;
  endproperty
  a_rst: assert property (p_rst) else $error("state not cleared by reset");
  a_oe_idle: assert property (p_oe_idle) else $error("lanes driven while idle");
  a_idle: assert property (p_idle) else $error("array active while idle");
  a_oe_data: assert property (p_oe_data) else $error("lanes driven outside data");
  a_dual_enh: assert property (p_dual_enh) else $error("enhance during dual read");
  a_step: assert property (p_step) else $error("address not linear");
  a_hold: assert property (p_hold) else $error("address moved without accept");
  a_wrap: assert property (p_wrap) else $error("wrap changed while idle");
  a_enh: assert property (p_enh) else $error("enhance changed while idle");
  a_lanes: assert property (p_lanes) else $error("bad lane enable");
  c_enh: cover property ($rose(status.enhance_mode));
  c_wrap: cover property ($rose(status.wrap_enable));
  c_acc: cover property (array_valid && array_ready);
endmodule

bind srmc_core srmc_core_chk i_chk (
  .clock, .rstn, .sclk, .chip_select_n, .io_lines_in, .io_lines_out, .io_lines_oe,
  .cfg, .status, .array_en, .array_addr, .array_valid, .array_data, .array_ready
);

// file: srmc_host.sv
// Purpose: Host controller model driving the serial link.
// Assumes: Mode 0 timing; sclk half period of four core clocks.
// Notes:   Released lanes show the inverse of the last value driven.
module srmc_host (
  input  wire logic       clock,
  input  wire logic [3:0] io_bus,
  output logic            sclk,
  output logic            chip_select_n,
  output logic [3:0]      io_drive,
  output logic            io_drive_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    io_drive = 4'h0;
    io_drive_oe = 1'b1;
  end
  task automatic half();
    repeat (4) @(posedge clock);
    #1;
  endtask
  // Device data is taken just before the rising edge, where it has settled.
  task automatic tick(input logic [3:0] v, output logic [3:0] r);
    io_drive = v;
    half();
    r = io_bus;
    sclk = 1'b1;
    half();
    sclk = 1'b0;
  endtask
  task automatic send(input logic [31:0] v, input int n, input int w);
    logic [3:0] r;
    for (int i = n - 1; i >= 0; i--) begin
      tick(4'((v >> (i * w)) & ((32'h1 << w) - 1)), r);
    end
  endtask
  task automatic recv(input int n, output logic [31:0] d);
    logic [3:0] r;
    d = 32'h0;
    io_drive_oe = 1'b0;
    repeat (n) begin
      tick(io_drive, r);
      d = {d[27:0], r};
    end
  endtask
  task automatic open_frame();
    chip_select_n = 1'b0;
    io_drive_oe = 1'b1;
    half();
  endtask
  task automatic close_frame();
    chip_select_n = 1'b1;
    repeat (2) half();
  endtask
endmodule

// file: tb.sv
// Purpose: Self-checking bench for srmc_core.
// Assumes: Array byte at an address is its low byte xor 5ah.
// Notes:   Double rate reads are not exercised by this host model.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   clock = 1'b0;
  logic                   rstn = 1'b0;
  logic                   sclk;
  logic                   chip_select_n;
  logic [3:0]             io_in;
  logic [3:0]             io_out;
  logic [3:0]             io_oe;
  logic [3:0]             h_io;
  logic                   h_oe;
  srmc_pkg::srmc_cfg_t    cfg = 5'b00100;
  srmc_pkg::srmc_status_t status;
  logic                   array_en;
  logic                   array_ready;
  logic                   array_valid = 1'b0;
  logic [31:0]            array_addr;
  logic [7:0]             array_data;
  logic [31:0]            d;
  logic [7:0]             stay [4] = '{8'ha5, 8'h5a, 8'hf0, 8'h0f};
  logic [7:0]             leave [4] = '{8'hff, 8'h00, 8'haa, 8'h55};
  int                     error_cnt = 0;
  int                     checks_done = 0;
  always #20 clock = ~clock;
  assign io_in = (io_oe & io_out) | (~io_oe & (h_oe ? h_io : ~h_io));
  // The array offers a byte every other clock, so the buffer also sees stalls.
  always @(posedge clock) #1 array_valid = ~array_valid;
  assign array_data = array_addr[7:0] ^ 8'h5a;
  srmc_core i_srmc_core (
    .clock, .rstn, .sclk, .chip_select_n, .io_lines_in(io_in), .io_lines_out(io_out),
    .io_lines_oe(io_oe), .cfg, .status, .array_en, .array_addr, .array_valid,
    .array_data, .array_ready
  );
  srmc_host i_host (
    .clock, .io_bus(io_in), .sclk, .chip_select_n, .io_drive(h_io), .io_drive_oe(h_oe)
  );
  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  function automatic logic [31:0] ex(input logic [31:0] a, input int blk);
    logic [31:0] r;
    logic [31:0] p;
    r = 32'h0;
    for (int i = 0; i < 4; i++) begin
      p = (blk == 0) ? a + i : (a & ~(blk - 1)) | ((a + i) & (blk - 1));
      r = {r[23:0], p[7:0] ^ 8'h5a};
    end
    return r;
  endfunction
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmd(input logic [7:0] v);
    if (cfg.quad_command_mode) i_host.send(32'(v), 2, 4);
    else i_host.send(32'(v), 8, 1);
  endtask
  // An opcode of zero stands for a frame that continues enhance mode.
  task automatic rd(input logic [7:0] op, input int an, input logic [31:0] a,
                    input logic [7:0] ind, input int nd);
    i_host.open_frame();
    if (op !== 8'h00) cmd(op);
    i_host.send(a, an, 4);
    i_host.send(32'(ind), 2, 4);
    i_host.send(32'h0, nd, 4);
    i_host.recv(8, d);
    i_host.close_frame();
  endtask
  task automatic setwrap(input logic [7:0] code);
    i_host.open_frame();
    cmd(srmc_pkg::OP_SET_BURST_LENGTH);
    cmd(code);
    i_host.close_frame();
  endtask
  // Enhance reset pattern, then more clocks that must not reach data.
  task automatic kill(input logic [31:0] v, input int n, input int w);
    i_host.open_frame();
    i_host.send(v, n, w);
    i_host.send(32'h0, 12, 1);
    check("oe", 32'h0, 32'(io_oe));
    i_host.close_frame();
    check("enh", 32'h0, 32'(status.enhance_mode));
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // --------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------
  initial begin
    repeat (60000) @(posedge clock);
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (4) @(posedge clock);
    #1 rstn = 1'b1;
    repeat (3) @(posedge clock);
    check("status", 32'h0, 32'(status));
    for (int i = 0; i < 4; i++) begin
      rd(srmc_pkg::OP_QUAD_IO_READ, 6, 32'h123450 + i, stay[i], 4);
      check("data", ex(32'h123450 + i, 0), d);
      check("enh", 32'h1, 32'(status.enhance_mode));
      rd(8'h00, 6, 32'h0abcf0 + i, leave[i], 4);
      check("data", ex(32'h0abcf0 + i, 0), d);
      check("enh", 32'h0, 32'(status.enhance_mode));
    end
    rd(srmc_pkg::OP_WIDE_ADDR_QUAD_IO_READ, 8, 32'h89abcdef, 8'ha5, 4);
    check("data", ex(32'h89abcdef, 0), d);
    rd(8'h00, 8, 32'hfedcba98, 8'h0f, 4);
    check("data", ex(32'hfedcba98, 0), d);
    kill(32'h3ff, 10, 1);
    for (int i = 0; i < 4; i++) begin
      {cfg.dummy_count_high, cfg.dummy_count_low} = 2'(i);
      rd(srmc_pkg::OP_QUAD_IO_READ, 6, 32'h200 + 7 * i, 8'h00, 4 + 2 * i);
      check("data", ex(32'h200 + 7 * i, 0), d);
    end
    cfg[1:0] = 2'b00;
    i_host.open_frame();
    cmd(srmc_pkg::OP_DUAL_IO_READ);
    i_host.send(32'ha5a5a5a5, 16, 2);
    i_host.send(32'h0, 4, 2);
    i_host.recv(8, d);
    i_host.close_frame();
    check("enh", 32'h0, 32'(status.enhance_mode));
    for (int i = 0; i < 4; i++) begin
      setwrap(8'(i));
      check("wrap", {29'h0, 1'b1, 2'(i)}, 32'(status[2:0]));
    end
    rd(srmc_pkg::OP_QUAD_IO_READ, 6, 32'h13e, 8'h00, 4);
    check("data", ex(32'h13e, 64), d);
    setwrap(8'h00);
    rd(srmc_pkg::OP_WIDE_ADDR_QUAD_IO_READ, 8, 32'h106, 8'h00, 4);
    check("data", ex(32'h106, 8), d);
    cfg.quad_command_mode = 1'b1;
    setwrap(8'h1f);
    check("wrap", 32'h0, 32'(status.wrap_enable));
    rd(srmc_pkg::OP_QUAD_IO_READ, 6, 32'h106, 8'hf0, 4);
    check("data", ex(32'h106, 0), d);
    check("enh", 32'h1, 32'(status.enhance_mode));
    kill(32'hffffffff, 8, 4);
    cfg.quad_command_mode = 1'b0;
    setwrap(8'h01);
    rd(srmc_pkg::OP_QUAD_IO_READ, 6, 32'h4c0, 8'h5a, 4);
    check("data", ex(32'h4c0, 16), d);
    check("status", 32'hd, 32'(status));
    i_host.open_frame();
    i_host.send(32'h12, 4, 4);
    rstn = 1'b0;
    i_host.close_frame();
    rstn = 1'b1;
    repeat (3) @(posedge clock);
    check("status", 32'h0, 32'(status));
    rd(srmc_pkg::OP_QUAD_IO_READ, 6, 32'h33e, 8'h00, 4);
    check("data", ex(32'h33e, 0), d);
    summarize();
  end
endmodule
